// ===== opdec_top.sv
// Purpose: AXI4-Lite reachable execution slice: add-with-carry, AND, shift left, bit branches
// Assumes: software loads opcode and operand byte, then writes the execute register
// Notes:   memory-mode shifts write their result back into the operand register
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module opdec_top #(
  parameter int ADDR_W = 8 // byte address width
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import opdec_pkg::*;

  // the decoder compares the low byte of the address, so narrower buses cannot work
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("opdec_top: ADDR_W must be at least 8");
  end

  // ==========================================================
  // helpers
  function automatic logic [1:0] nz_of(input logic [7:0] v);
    nz_of = {v[7], v == 8'h00};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    if ((a >> 8) != '0) mapped = 1'b0;
    else if (lo == OFF_OPCODE || lo == OFF_OPERAND || lo == OFF_ACC) mapped = 1'b1;
    else if (lo == OFF_FLAGS || lo == OFF_EXEC || lo == OFF_DECODE) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  // ==========================================================
  // write channel: address and data latched independently
  logic aw_hold_ff, w_hold_ff, bvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff;
  logic wr_en;

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign wr_en = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wbyte_ff <= BYTE_RST;
      wlane_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      wbyte_ff <= s_axi_wdata[7:0];
      wlane_ff <= s_axi_wstrb[0];
    end else if (wr_en) begin
      w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // only the low byte lane carries data; the upper lanes are ignored
  logic wr_go, wr_opcode, wr_operand, wr_acc, wr_flags, wr_exec;
  assign wr_go = wr_en && wlane_ff && (awaddr_ff >> 8) == '0;
  assign wr_opcode = wr_go && awaddr_ff[7:0] == OFF_OPCODE;
  assign wr_operand = wr_go && awaddr_ff[7:0] == OFF_OPERAND;
  assign wr_acc = wr_go && awaddr_ff[7:0] == OFF_ACC;
  assign wr_flags = wr_go && awaddr_ff[7:0] == OFF_FLAGS;
  assign wr_exec = wr_go && awaddr_ff[7:0] == OFF_EXEC;

  // ==========================================================
  // architectural state; no timers anywhere, so a held clock loses nothing
  logic [7:0] opcode_ff, operand_ff, acc_ff, flags_ff;
  logic taken_ff;

  opdec_class_t cls;
  opdec_mode_t mode;
  logic [2:0] bsel;

  opdec_classify u_classify (
    .opcode(opcode_ff),
    .op_class(cls),
    .op_mode(mode),
    .bit_sel(bsel)
  );

  // ==========================================================
  // execution datapath
  logic [8:0] sum9;
  logic [7:0] and_res, shl_src, shl_res;
  logic adc_v, br_taken;

  always_comb begin
    sum9 = {1'b0, acc_ff} + {1'b0, operand_ff} + {8'h00, flags_ff[FLG_C]};
    adc_v = ~(acc_ff[7] ^ operand_ff[7]) & (acc_ff[7] ^ sum9[7]);
    and_res = acc_ff & operand_ff;
    shl_src = (mode == OPDEC_M_ACC) ? acc_ff : operand_ff;
    shl_res = {shl_src[6:0], 1'b0};
    br_taken = 1'b0;
    if (cls == OPDEC_CLS_BBR) br_taken = ~operand_ff[bsel];
    else if (cls == OPDEC_CLS_BBS) br_taken = operand_ff[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) opcode_ff <= BYTE_RST;
    else if (wr_opcode) opcode_ff <= wbyte_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) operand_ff <= BYTE_RST;
    else if (wr_operand) operand_ff <= wbyte_ff;
    else if (wr_exec && cls == OPDEC_CLS_SHL && mode != OPDEC_M_ACC)
      operand_ff <= shl_res;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= BYTE_RST;
    end else if (wr_acc) begin
      acc_ff <= wbyte_ff;
    end else if (wr_exec) begin
      case (cls)
        OPDEC_CLS_ADC: acc_ff <= sum9[7:0];
        OPDEC_CLS_AND: acc_ff <= and_res;
        OPDEC_CLS_SHL: if (mode == OPDEC_M_ACC) acc_ff <= shl_res;
        default: acc_ff <= acc_ff;
      endcase
    end
  end

  // bit 5 always reads one whatever is written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= FLAGS_RST;
    end else if (wr_flags) begin
      flags_ff <= wbyte_ff | FLAGS_ONE_MASK;
    end else if (wr_exec) begin
      case (cls)
        OPDEC_CLS_ADC: begin
          {flags_ff[FLG_N], flags_ff[FLG_Z]} <= nz_of(sum9[7:0]);
          flags_ff[FLG_V] <= adc_v;
          flags_ff[FLG_C] <= sum9[8];
        end
        OPDEC_CLS_AND: {flags_ff[FLG_N], flags_ff[FLG_Z]} <= nz_of(and_res);
        OPDEC_CLS_SHL: begin
          {flags_ff[FLG_N], flags_ff[FLG_Z]} <= nz_of(shl_res);
          flags_ff[FLG_C] <= shl_src[7];
        end
        // bit branches and unknown opcodes leave the flags alone
        default: flags_ff <= flags_ff;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) taken_ff <= 1'b0;
    else if (wr_exec) taken_ff <= br_taken;
  end

  // ==========================================================
  // read channel: one cycle from address handshake to data
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_word;
  logic [7:0] ra;

  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    rd_word = 32'h0000_0000;
    ra = s_axi_araddr[7:0];
    if ((s_axi_araddr >> 8) != '0) rd_word = 32'h0000_0000;
    else if (ra == OFF_OPCODE) rd_word[7:0] = opcode_ff;
    else if (ra == OFF_OPERAND) rd_word[7:0] = operand_ff;
    else if (ra == OFF_ACC) rd_word[7:0] = acc_ff;
    else if (ra == OFF_FLAGS) rd_word[7:0] = flags_ff;
    else if (ra == OFF_DECODE) begin
      rd_word[DEC_CLASS_LSB +: 4] = cls;
      rd_word[DEC_MODE_LSB +: 4] = mode;
      rd_word[DEC_BIT_LSB +: 3] = bsel;
      rd_word[DEC_TAKEN] = taken_ff;
      rd_word[DEC_VALID] = cls != OPDEC_CLS_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule // opdec_top

`default_nettype wire

// ===== opdec_decode.sv
// Purpose: package and opcode classifier for the arithmetic/bit-branch slice
// Assumes: opcode is a plain byte held stable by the caller
// Notes:   pure combinational; unknown opcodes report class none
`timescale 1ns/1ns
`default_nettype none

package opdec_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_OPCODE = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_EXEC = 8'h10;
  localparam logic [7:0] OFF_DECODE = 8'h14;
  // ==========================================================
  // status byte field positions, bit 7 down to bit 0
  localparam int FLG_N = 7;
  localparam int FLG_V = 6;
  localparam int FLG_ONE = 5;
  localparam int FLG_B = 4;
  localparam int FLG_D = 3;
  localparam int FLG_I = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_RST = 8'h20;
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h20;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ==========================================================
  // decode status word layout
  localparam int DEC_CLASS_LSB = 0;
  localparam int DEC_MODE_LSB = 4;
  localparam int DEC_BIT_LSB = 8;
  localparam int DEC_TAKEN = 12;
  localparam int DEC_VALID = 13;
  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // opcode constants
  localparam logic [7:0] OP_ADC_ABS = 8'h6D;
  localparam logic [7:0] OP_ADC_ABX = 8'h7D;
  localparam logic [7:0] OP_ADC_ABY = 8'h79;
  localparam logic [7:0] OP_ADC_IMM = 8'h69;
  localparam logic [7:0] OP_ADC_ZP = 8'h65;
  localparam logic [7:0] OP_ADC_ZXI = 8'h61;
  localparam logic [7:0] OP_ADC_ZPX = 8'h75;
  localparam logic [7:0] OP_ADC_ZPI = 8'h72;
  localparam logic [7:0] OP_ADC_IZY = 8'h71;
  localparam logic [7:0] OP_AND_ABS = 8'h2D;
  localparam logic [7:0] OP_AND_ABX = 8'h3D;
  localparam logic [7:0] OP_AND_ABY = 8'h39;
  localparam logic [7:0] OP_AND_IMM = 8'h29;
  localparam logic [7:0] OP_AND_ZP = 8'h25;
  localparam logic [7:0] OP_AND_ZXI = 8'h21;
  localparam logic [7:0] OP_AND_ZPX = 8'h35;
  localparam logic [7:0] OP_AND_ZPI = 8'h32;
  localparam logic [7:0] OP_AND_IZY = 8'h31;
  localparam logic [7:0] OP_SHL_ABS = 8'h0E;
  localparam logic [7:0] OP_SHL_ABX = 8'h1E;
  localparam logic [7:0] OP_SHL_ACC = 8'h0A;
  localparam logic [7:0] OP_SHL_ZP = 8'h06;
  localparam logic [7:0] OP_SHL_ZPX = 8'h16;
  localparam logic [3:0] BRANCH_LOW_NIB = 4'hF;
  localparam logic [7:0] OP_BIT0_SET = 8'h8F;

  typedef enum logic [3:0] {
    OPDEC_CLS_NONE, OPDEC_CLS_ADC, OPDEC_CLS_AND, OPDEC_CLS_SHL, OPDEC_CLS_BBR, OPDEC_CLS_BBS
  } opdec_class_t;

  typedef enum logic [3:0] {
    OPDEC_M_NONE, OPDEC_M_ABS, OPDEC_M_ABX, OPDEC_M_ABY, OPDEC_M_IMM, OPDEC_M_ZP,
    OPDEC_M_ZXI, OPDEC_M_ZPX, OPDEC_M_ZPI, OPDEC_M_IZY, OPDEC_M_ACC, OPDEC_M_REL
  } opdec_mode_t;
endpackage

module opdec_classify (
  input wire logic [7:0] opcode, // byte to classify
  output opdec_pkg::opdec_class_t op_class, // operation class
  output opdec_pkg::opdec_mode_t op_mode, // addressing mode
  output logic [2:0] bit_sel // memory bit tested by bit branches
);
  import opdec_pkg::*;

  always_comb begin
    op_class = OPDEC_CLS_NONE;
    op_mode = OPDEC_M_NONE;
    bit_sel = opcode[6:4];
    case (opcode)
      OP_ADC_ABS: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ABS; end
      OP_ADC_ABX: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ABX; end
      OP_ADC_ABY: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ABY; end
      OP_ADC_IMM: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_IMM; end
      OP_ADC_ZP: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ZP; end
      OP_ADC_ZXI: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ZXI; end
      OP_ADC_ZPX: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ZPX; end
      OP_ADC_ZPI: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_ZPI; end
      OP_ADC_IZY: begin op_class = OPDEC_CLS_ADC; op_mode = OPDEC_M_IZY; end
      OP_AND_ABS: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ABS; end
      OP_AND_ABX: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ABX; end
      OP_AND_ABY: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ABY; end
      OP_AND_IMM: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_IMM; end
      OP_AND_ZP: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ZP; end
      OP_AND_ZXI: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ZXI; end
      OP_AND_ZPX: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ZPX; end
      OP_AND_ZPI: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_ZPI; end
      OP_AND_IZY: begin op_class = OPDEC_CLS_AND; op_mode = OPDEC_M_IZY; end
      OP_SHL_ABS: begin op_class = OPDEC_CLS_SHL; op_mode = OPDEC_M_ABS; end
      OP_SHL_ABX: begin op_class = OPDEC_CLS_SHL; op_mode = OPDEC_M_ABX; end
      OP_SHL_ACC: begin op_class = OPDEC_CLS_SHL; op_mode = OPDEC_M_ACC; end
      OP_SHL_ZP: begin op_class = OPDEC_CLS_SHL; op_mode = OPDEC_M_ZP; end
      OP_SHL_ZPX: begin op_class = OPDEC_CLS_SHL; op_mode = OPDEC_M_ZPX; end
      OP_BIT0_SET: begin
        op_class = OPDEC_CLS_BBS;
        op_mode = OPDEC_M_REL;
      end
      default: begin
        // bit-clear branches: low nibble F, bit index in 6:4, bit 7 low
        if (opcode[3:0] == BRANCH_LOW_NIB && !opcode[7]) begin
          op_class = OPDEC_CLS_BBR;
          op_mode = OPDEC_M_REL;
        end
      end
    endcase
  end
endmodule // opdec_classify

`default_nettype wire

// ===== opdec_bus_model.sv
// Purpose: bus master standing in for the processor side of the slice
// Assumes: one write and one read at most in flight
// Notes:   random ready delays exercise slow answers
`timescale 1ns/1ns
`default_nettype none

module opdec_bus_model (
  input wire logic aclk, // bus clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // response valid
  output logic s_axi_bready, // response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  int seed = 32'h5245;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // ==========================================================
  // write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = {$random(seed)} % 3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    // stalled answers must stand unharmed
    repeat (n) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // ==========================================================
  // read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = {$random(seed)} % 3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (n) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // opdec_bus_model

`default_nettype wire

// ===== opdec_properties.sv
// Purpose: bus and status-byte properties of the execution slice
// Assumes: bound to the top module, single clock domain
// Notes:   data results are judged by the bench
`timescale 1ns/1ns
`default_nettype none

module opdec_props #(
  parameter int ADDR_W = 8 // byte address width
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import opdec_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence flags_rd;
    rd_taken ##0 (s_axi_araddr == ADDR_W'(OFF_FLAGS));
  endsequence

  // ==========================================================
  // answers and holding
  // halves are held one cycle, the answer rises on the edge after that
  wr_answer_a: assert property (wr_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // ==========================================================
  // status byte
  flag_one_a: assert property (flags_rd |=> s_axi_rvalid && s_axi_rdata[FLG_ONE])
    else $error("status bit five low");
endmodule // opdec_props

bind opdec_top opdec_props #(.ADDR_W(ADDR_W)) u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the execution slice
// Assumes: registers reached only through the bus model
// Notes:   operands random from a fixed seed, corners by hand
`timescale 1ns/1ns
`default_nettype none

module tb;
  import opdec_pkg::*;
  localparam logic [7:0] ADC_OPS [9] = '{8'h6D, 8'h7D, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75,
    8'h72, 8'h71};
  localparam logic [7:0] AND_OPS [9] = '{8'h2D, 8'h3D, 8'h39, 8'h29, 8'h25, 8'h21, 8'h35,
    8'h32, 8'h31};
  localparam logic [7:0] SHL_OPS [5] = '{8'h0E, 8'h1E, 8'h0A, 8'h06, 8'h16};
  localparam logic [3:0] SHL_MODES [5] = '{4'h1, 4'h2, 4'hA, 4'h5, 4'h7};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int seed = 32'h5245;
  int bad_count = 0;
  int check_count = 0;

  opdec_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  opdec_bus_model u_bus (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial forever #25 aclk = ~aclk; // free-running oscillator straight

  // ==========================================================
  // compares and bus helpers
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_resp(input string s, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    u_bus.wr(a, {24'h0, d}, resp);
    chk_resp($sformatf("write resp %h", a), er, resp);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFF, input logic [1:0] er = RESP_OKAY);
    u_bus.rd(a, rdat, resp);
    chk($sformatf("reg %h", a), e & m, rdat & m);
    chk_resp($sformatf("read resp %h", a), er, resp);
  endtask
  function automatic logic [7:0] rb();
    return 8'($random(seed));
  endfunction

  // ==========================================================
  // expected effect of one execute
  function automatic void predict(input logic [7:0] op, a, m, f,
      output logic [7:0] ea, em, ef, output logic [31:0] dec);
    logic [8:0] s;
    logic [7:0] r;
    logic [3:0] cls, md;
    logic t;
    s = {1'b0, a} + {1'b0, m} + 9'(f[FLG_C]);
    {ea, em, ef, t, cls, md} = {a, m, f, 1'b0, 4'h0, 4'h0};
    // ADC and AND mode codes follow the order of their opcode tables; shift mode codes come from SHL_MODES
    foreach (ADC_OPS[i]) if (op == ADC_OPS[i] || op == AND_OPS[i]) md = 4'(i + 1);
    foreach (SHL_OPS[i]) if (op == SHL_OPS[i]) md = SHL_MODES[i];
    if (op inside {ADC_OPS}) begin
      {cls, ef[FLG_C], ea} = {4'h1, s};
      ef[FLG_V] = (a[7] == m[7]) && (s[7] != a[7]);
    end else if (op inside {AND_OPS}) begin
      {cls, ea} = {4'h2, a & m};
    end else if (op inside {SHL_OPS}) begin
      cls = 4'h3;
      if (op == 8'h0A) {ef[FLG_C], ea} = {a, 1'b0};
      else {ef[FLG_C], em} = {m, 1'b0};
    end else if (op[3:0] == 4'hF && op <= 8'h8F) begin
      cls = op[7] ? 4'h5 : 4'h4;
      md = 4'hB;
      t = (m[op[6:4]] == op[7]);
    end
    r = (cls == 4'h3 && op != 8'h0A) ? em : ea;
    if (cls inside {4'h1, 4'h2, 4'h3}) {ef[FLG_N], ef[FLG_Z]} = {r[7], r == 8'h00};
    dec = {18'h0, cls != 4'h0, t, 1'b0, op[6:4], md, cls};
  endfunction

  task automatic run_op(input logic [7:0] op, a, m, f);
    logic [7:0] ea, em, ef;
    logic [31:0] dec;
    predict(op, a, m, f | FLAGS_ONE_MASK, ea, em, ef, dec);
    wr(OFF_OPCODE, op);
    wr(OFF_OPERAND, m);
    wr(OFF_ACC, a);
    wr(OFF_FLAGS, f);
    wr(OFF_EXEC, 8'h01);
    rchk(OFF_ACC, {24'h0, ea});
    rchk(OFF_OPERAND, {24'h0, em});
    rchk(OFF_FLAGS, {24'h0, ef});
    rchk(OFF_DECODE, dec, (dec[3:0] > 4'h3) ? 32'h37FF : 32'h30FF);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_FLAGS, 32'h20);
    rchk(OFF_ACC, 32'h0);
    wr(OFF_FLAGS, 8'h00);
    rchk(OFF_FLAGS, 32'h20);
    wr(8'h40, 8'h5A, RESP_SLVERR);
    rchk(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    $display("reset and map test finished");
    foreach (ADC_OPS[i]) run_op(ADC_OPS[i], rb(), rb(), rb());
    run_op(8'h69, 8'h80, 8'h80, 8'h00);
    run_op(8'h6D, 8'h7F, 8'h00, 8'h01);
    $display("add test finished");
    foreach (AND_OPS[i]) run_op(AND_OPS[i], rb(), rb(), rb());
    run_op(8'h29, 8'hF0, 8'h0F, 8'hC3);
    $display("and test finished");
    foreach (SHL_OPS[i]) run_op(SHL_OPS[i], rb(), rb(), rb());
    run_op(8'h0A, 8'h80, 8'h55, 8'h00);
    $display("shift test finished");
    for (int n = 0; n < 9; n++) run_op(8'(n * 16 + 15), rb(), rb(), rb());
    run_op(8'h7F, 8'h00, 8'h7F, 8'hFF);
    run_op(8'h8F, 8'h00, 8'h01, 8'hFF);
    run_op(8'hEA, 8'h12, 8'h34, 8'hC3);
    $display("branch test finished");
    give_verdict();
  end
endmodule // tb

`default_nettype wire
